//--- rtl/vispt_pkg.sv
// Purpose: Shared constants for the video input select and power timer block
// Assumes: 50 MHz ref_clk, 32-bit register bus with byte addresses
// Notes:   Duration codes index fixed lookup tables below
package vispt_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned SECS_PER_MIN  = 60;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SELECT  = 8'h04;
  localparam logic [7:0] REG_PRIO    = 8'h08;
  localparam logic [7:0] REG_MOVE    = 8'h0C;
  localparam logic [7:0] REG_TIMEOUT = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_AUTO_BIT  = 0;
  localparam int CTRL_DDC_LSB   = 1;
  localparam int SEL_CUR_LSB    = 0;
  localparam int SEL_DDC_LSB    = 4;
  localparam int MOVE_IN_LSB    = 0;
  localparam int MOVE_UP_BIT    = 8;
  localparam int MOVE_DOWN_BIT  = 9;
  localparam int TO_SPLASH_LSB  = 0;
  localparam int TO_SBY_LSB     = 4;
  localparam int TO_SLP_LSB     = 8;
  localparam int ST_SHOWN_LSB   = 0;
  localparam int ST_VALID_BIT   = 2;
  localparam int ST_PWR_LSB     = 4;
  localparam int ST_LOGO_BIT    = 6;
  localparam int ST_ACTIVE_LSB  = 8;
  localparam int ST_DDCEN_LSB   = 12;

  // ---------------------------------------------------------------
  // Inputs: 0 DVI 1, 1 DP 1, 2 DVI 2, 3 DP 2
  // ---------------------------------------------------------------
  localparam int         MAX_INPUTS = 4;
  localparam logic [3:0] FIT_FULL   = 4'h3 << 2 | 4'h3;
  localparam logic [3:0] FIT_SMALL  = 4'h3;
  localparam logic [7:0] RANK_RESET = 8'hE4;

  // ---------------------------------------------------------------
  // Modes and codes
  // ---------------------------------------------------------------
  localparam logic [1:0] DDC_MANUAL = 2'h0;
  localparam logic [1:0] DDC_AUTO   = 2'h1;
  localparam logic [1:0] DDC_OFF    = 2'h2;
  localparam logic       AUTO_RESET = 1'b1;

  localparam logic [3:0] SPLASH_NONE    = 4'h0;
  localparam logic [3:0] SPLASH_PERSIST = 4'h9;
  localparam logic [3:0] SBY_STAY_ON    = 4'h5;
  localparam logic [3:0] SLP_NEVER      = 4'h5;
  localparam logic [3:0] SPLASH_RESET   = SPLASH_NONE;
  localparam logic [3:0] SBY_RESET      = 4'h0;
  localparam logic [3:0] SLP_RESET      = SLP_NEVER;

  typedef enum logic [1:0] {PWR_LOGO, PWR_ON, PWR_STANDBY, PWR_SLEEP} vispt_pwr_t;

  // Splash codes 1..8 give 1,2,3,4,5,10,30,60 s
  function automatic logic [11:0] vispt_splash_secs(input logic [3:0] code);
    case (code)
      4'h1:    vispt_splash_secs = 12'd1;
      4'h2:    vispt_splash_secs = 12'd2;
      4'h3:    vispt_splash_secs = 12'd3;
      4'h4:    vispt_splash_secs = 12'd4;
      4'h5:    vispt_splash_secs = 12'd5;
      4'h6:    vispt_splash_secs = 12'd10;
      4'h7:    vispt_splash_secs = 12'd30;
      default: vispt_splash_secs = 12'd60;
    endcase
  endfunction

  // Codes 0..4 give 3,5,10,30,60 units
  function automatic logic [11:0] vispt_step_units(input logic [3:0] code);
    case (code)
      4'h0:    vispt_step_units = 12'd3;
      4'h1:    vispt_step_units = 12'd5;
      4'h2:    vispt_step_units = 12'd10;
      4'h3:    vispt_step_units = 12'd30;
      default: vispt_step_units = 12'd60;
    endcase
  endfunction

endpackage

//--- rtl/vispt_sec_tick.sv
// Purpose: One-second tick generator with synchronous restart
// Assumes: CYCLES is at least 2
// Notes:   Tick is a one-cycle registered pulse
`timescale 1ns/1ps
module vispt_sec_tick
  import vispt_pkg::*;
#(
  parameter int unsigned CYCLES = SEC_CYCLES
)
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clr,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } vispt_tick_t;

  vispt_tick_t s_q;
  vispt_tick_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (clr)
    begin
      s_d.cnt = 32'h0000_0000;
    end
    else if (s_q.cnt == 32'(CYCLES - 1))
    begin
      s_d.cnt  = 32'h0000_0000;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

endmodule

//--- rtl/vispt_prio_pick.sv
// Purpose: Pick highest ranked active input
// Assumes: rank slot 0 is highest priority, two bits per slot
// Notes:   Pure decode, no state
`timescale 1ns/1ps
module vispt_prio_pick
  import vispt_pkg::*;
(
  input  wire logic [7:0] rank,
  input  wire logic [3:0] active,
  output logic            found,
  output logic [1:0]      pick
);

  always_comb
  begin
    found = 1'b0;
    pick  = 2'h0;
    // Walk lowest to highest so the best slot wins last
    for (int k = MAX_INPUTS - 1; k >= 0; k--)
    begin
      if (active[rank[2*k +: 2]])
      begin
        found = 1'b1;
        pick  = rank[2*k +: 2];
      end
    end
  end

endmodule

//--- rtl/vispt_top.sv
// Purpose: Input selection, DDC/CI gating and splash/standby/sleep timers
// Assumes: sigActive, powerBtn and mccs inputs synchronous to ref_clk
// Notes:   Avalon-MM slave answers one cycle after a request is seen
//
// Behaviour
// - Manual mode shows only configured current input
// - Auto mode keeps checking all fitted inputs
// - Priority order adjustable by moving inputs up/down
// - Auto shows highest-priority active input
// - On loss, fall to next valid input
// - Return to higher input when it revives
// - Two-input build selects only DVI 1, DP 1
// - DDC manual: accept only designated input
// - DDC auto: accept on all inputs
// - DDC off: accept on no input
// - Boot logo: code resets to none, so logo ends at first edge after reset; 1-60 s and persistent codes have no effect
// - Standby after 3-60 s no signal, or never
// - Sleep after 3-60 min standby, or never
// - Sleep wakes on power command or button
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module vispt_top
  import vispt_pkg::*;
#(
  parameter int unsigned NUM_INPUTS  = 4,
  parameter int unsigned TICK_CYCLES = SEC_CYCLES
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  sigActive,
  input  wire logic        powerBtn,
  input  wire logic [3:0]  mccsPwrReq,
  input  wire logic        mccsPwrOn,
  output logic [1:0]       shownInput,
  output logic             shownValid,
  output logic [3:0]       ddcEnable,
  output logic             logoOn,
  output logic [1:0]       powerState
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        autoMode;
    logic [1:0]  ddcMode;
    logic [1:0]  curIn;
    logic [1:0]  ddcIn;
    logic [7:0]  rank;
    logic [3:0]  splashCode;
    logic [3:0]  sbyCode;
    logic [3:0]  slpCode;
    vispt_pwr_t  pwr;
    logic [11:0] secCnt;
    logic [1:0]  shown;
    logic        shownValid;
    logic [3:0]  ddcEn;
    logic        logo;
    logic        waitReq;
    logic [31:0] rdata;
  } vispt_state_t;

  localparam logic [3:0] FIT_MASK = (NUM_INPUTS == 2) ? FIT_SMALL : FIT_FULL;

  vispt_state_t s_q;
  vispt_state_t s_d;
  logic         tick;
  logic         tickClr;
  logic         pickFound;
  logic [1:0]   pickIdx;
  logic [3:0]   activeFit;
  logic         access;
  logic         doWrite;
  logic [31:0]  wval;
  logic [11:0]  nextSec;
  logic         wake;

  // Merge write data into a register image by byte lane
  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Find the slot holding a given input
  function automatic logic [1:0] slot_of(input logic [7:0] rk, input logic [1:0] in);
    logic [1:0] p;
    p = 2'h0;
    for (int k = 0; k < MAX_INPUTS; k++)
    begin
      if (rk[2*k +: 2] == in)
        p = 2'(k);
    end
    return p;
  endfunction

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  vispt_sec_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr     (tickClr),
    .tick    (tick)
  );

  assign activeFit = sigActive & FIT_MASK;

  vispt_prio_pick u_pick (
    .rank   (s_q.rank),
    .active (activeFit),
    .found  (pickFound),
    .pick   (pickIdx)
  );

  assign access  = avs_read | avs_write;
  assign doWrite = avs_write & ~s_q.waitReq;
  assign nextSec = s_q.secCnt + 12'h001;
  assign wake    = |(mccsPwrReq & s_q.ddcEn) & mccsPwrOn;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [1:0] p;
    logic [1:0] q;
    logic [1:0] mvIn;
    p    = 2'h0;
    q    = 2'h0;
    mvIn = 2'h0;
    wval = 32'h0000_0000;
    s_d  = s_q;
    tickClr = 1'b0;

    // Bus handshake: one wait cycle, then acknowledge
    if (access && s_q.waitReq)
    begin
      s_d.waitReq = 1'b0;
      case (avs_address)
        REG_CTRL:
          s_d.rdata = {29'h0, s_q.ddcMode, s_q.autoMode};
        REG_SELECT:
          s_d.rdata = {26'h0, s_q.ddcIn, 2'h0, s_q.curIn};
        REG_PRIO:
          s_d.rdata = {24'h0, s_q.rank};
        REG_TIMEOUT:
          s_d.rdata = {20'h0, s_q.slpCode, s_q.sbyCode, s_q.splashCode};
        REG_STATUS:
          s_d.rdata = {16'h0, s_q.ddcEn, activeFit, 1'b0, s_q.logo,
                       s_q.pwr, 1'b0, s_q.shownValid, s_q.shown};
        default:
          s_d.rdata = 32'h0000_0000;
      endcase
    end
    else
    begin
      s_d.waitReq = 1'b1;
    end

    // Register writes take effect at the acknowledge edge
    if (doWrite)
    begin
      case (avs_address)
        REG_CTRL:
        begin
          wval = merge_be({29'h0, s_q.ddcMode, s_q.autoMode}, avs_writedata, avs_byteenable);
          s_d.autoMode = wval[CTRL_AUTO_BIT];
          if (wval[CTRL_DDC_LSB +: 2] != 2'h3)
            s_d.ddcMode = wval[CTRL_DDC_LSB +: 2];
        end
        REG_SELECT:
        begin
          wval = merge_be({26'h0, s_q.ddcIn, 2'h0, s_q.curIn}, avs_writedata, avs_byteenable);
          if (FIT_MASK[wval[SEL_CUR_LSB +: 2]])
            s_d.curIn = wval[SEL_CUR_LSB +: 2];
          if (FIT_MASK[wval[SEL_DDC_LSB +: 2]])
            s_d.ddcIn = wval[SEL_DDC_LSB +: 2];
        end
        REG_MOVE:
        begin
          wval = merge_be(32'h0000_0000, avs_writedata, avs_byteenable);
          mvIn = wval[MOVE_IN_LSB +: 2];
          p    = slot_of(s_q.rank, mvIn);
          // Swap with the neighbour slot; ends of the list ignore the move
          if (wval[MOVE_UP_BIT] && !wval[MOVE_DOWN_BIT] && p != 2'h0)
          begin
            q = p - 2'h1;
            s_d.rank[2*p +: 2] = s_q.rank[2*q +: 2];
            s_d.rank[2*q +: 2] = mvIn;
          end
          else if (wval[MOVE_DOWN_BIT] && !wval[MOVE_UP_BIT] && p != 2'h3)
          begin
            q = p + 2'h1;
            s_d.rank[2*p +: 2] = s_q.rank[2*q +: 2];
            s_d.rank[2*q +: 2] = mvIn;
          end
        end
        REG_TIMEOUT:
        begin
          wval = merge_be({20'h0, s_q.slpCode, s_q.sbyCode, s_q.splashCode},
                          avs_writedata, avs_byteenable);
          if (wval[TO_SPLASH_LSB +: 4] <= SPLASH_PERSIST)
            s_d.splashCode = wval[TO_SPLASH_LSB +: 4];
          if (wval[TO_SBY_LSB +: 4] <= SBY_STAY_ON)
            s_d.sbyCode = wval[TO_SBY_LSB +: 4];
          if (wval[TO_SLP_LSB +: 4] <= SLP_NEVER)
            s_d.slpCode = wval[TO_SLP_LSB +: 4];
        end
        default:
        begin
          wval = 32'h0000_0000;
        end
      endcase
    end

    // Displayed input
    if (!s_q.autoMode)
    begin
      s_d.shown      = s_q.curIn;
      s_d.shownValid = sigActive[s_q.curIn];
    end
    else if (pickFound)
    begin
      s_d.shown      = pickIdx;
      s_d.shownValid = 1'b1;
    end
    else
    begin
      s_d.shownValid = 1'b0;
    end

    // DDC/CI acceptance per input
    case (s_q.ddcMode)
      DDC_MANUAL: s_d.ddcEn = FIT_MASK & (4'h1 << s_q.ddcIn);
      DDC_AUTO:   s_d.ddcEn = FIT_MASK;
      default:    s_d.ddcEn = 4'h0;
    endcase

    // Power and timers
    case (s_q.pwr)
      PWR_LOGO:
      begin
        if (s_q.splashCode == SPLASH_NONE)
        begin
          s_d.pwr    = PWR_ON;
          s_d.secCnt = 12'h000;
          tickClr    = 1'b1;
        end
        else if (s_q.splashCode != SPLASH_PERSIST && tick)
        begin
          s_d.secCnt = nextSec;
          if (nextSec >= vispt_splash_secs(s_q.splashCode))
          begin
            s_d.pwr    = PWR_ON;
            s_d.secCnt = 12'h000;
            tickClr    = 1'b1;
          end
        end
      end
      PWR_ON:
      begin
        if (powerBtn)
        begin
          s_d.pwr    = PWR_SLEEP;
          s_d.secCnt = 12'h000;
        end
        else if (s_q.shownValid || s_q.sbyCode == SBY_STAY_ON)
        begin
          s_d.secCnt = 12'h000;
          tickClr    = 1'b1;
        end
        else if (tick)
        begin
          s_d.secCnt = nextSec;
          if (nextSec >= vispt_step_units(s_q.sbyCode))
          begin
            s_d.pwr    = PWR_STANDBY;
            s_d.secCnt = 12'h000;
            tickClr    = 1'b1;
          end
        end
      end
      PWR_STANDBY:
      begin
        if (|activeFit || powerBtn || wake)
        begin
          s_d.pwr    = PWR_ON;
          s_d.secCnt = 12'h000;
          tickClr    = 1'b1;
        end
        else if (s_q.slpCode != SLP_NEVER && tick)
        begin
          s_d.secCnt = nextSec;
          if (nextSec >= 12'(vispt_step_units(s_q.slpCode) * SECS_PER_MIN))
          begin
            s_d.pwr    = PWR_SLEEP;
            s_d.secCnt = 12'h000;
          end
        end
      end
      PWR_SLEEP:
      begin
        if (powerBtn || wake)
        begin
          s_d.pwr    = PWR_ON;
          s_d.secCnt = 12'h000;
          tickClr    = 1'b1;
        end
      end
      default:
      begin
        s_d.pwr = PWR_ON;
      end
    endcase

    // Logo output registered so the pin comes straight from a flop
    s_d.logo = (s_d.pwr == PWR_LOGO);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q            <= '0;
      s_q.autoMode   <= AUTO_RESET;
      s_q.ddcMode    <= DDC_AUTO;
      s_q.rank       <= RANK_RESET;
      s_q.splashCode <= SPLASH_RESET;
      s_q.sbyCode    <= SBY_RESET;
      s_q.slpCode    <= SLP_RESET;
      s_q.pwr        <= PWR_LOGO;
      s_q.logo       <= 1'b1;
      s_q.waitReq    <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.waitReq;
  assign shownInput      = s_q.shown;
  assign shownValid      = s_q.shownValid;
  assign ddcEnable       = s_q.ddcEn;
  assign logoOn          = s_q.logo;
  assign powerState      = s_q.pwr;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic rankPerm;
  always_comb
  begin
    logic [3:0] seen;
    seen = 4'h0;
    for (int k = 0; k < MAX_INPUTS; k++)
      seen[s_q.rank[2*k +: 2]] = 1'b1;
    rankPerm = (seen == 4'hF);
  end

  a_manual_shown: assert property (!s_q.autoMode |=> shownInput == $past(s_q.curIn))
    else $error("manual mode shows wrong input");
  a_auto_best: assert property (s_q.autoMode && pickFound |=>
                                shownValid && shownInput == $past(pickIdx))
    else $error("auto mode not showing best active input");
  a_fitted_only: assert property (shownValid && s_q.autoMode |-> FIT_MASK[shownInput])
    else $error("unfitted input shown");
  a_rank_perm: assert property (rankPerm)
    else $error("priority order is not a permutation");
  a_ddc_manual: assert property (s_q.ddcMode == DDC_MANUAL |=>
                                 ddcEnable == (FIT_MASK & (4'h1 << $past(s_q.ddcIn))))
    else $error("manual DDC/CI gating wrong");
  a_ddc_auto: assert property (s_q.ddcMode == DDC_AUTO |=> ddcEnable == FIT_MASK)
    else $error("auto DDC/CI not on all inputs");
  a_ddc_off: assert property (s_q.ddcMode == DDC_OFF |=> ddcEnable == 4'h0)
    else $error("DDC/CI accepted while off");
  a_logo_none: assert property (logoOn && s_q.splashCode == SPLASH_NONE |=> !logoOn)
    else $error("logo shown with no-logo setting");
  a_stay_on: assert property (s_q.pwr == PWR_ON && s_q.sbyCode == SBY_STAY_ON
                              && !powerBtn |=> s_q.pwr == PWR_ON)
    else $error("standby entered with stay-on");
  a_sby_cancel: assert property (s_q.pwr == PWR_ON && shownValid |=>
                                 s_q.pwr != PWR_STANDBY && s_q.secCnt == 12'h000)
    else $error("standby countdown not cancelled");
  a_sby_detect: assert property (s_q.pwr == PWR_STANDBY && |activeFit |=>
                                 s_q.pwr == PWR_ON)
    else $error("standby missed active input");
  a_no_sleep: assert property (s_q.pwr == PWR_STANDBY && s_q.slpCode == SLP_NEVER |=>
                               s_q.pwr != PWR_SLEEP)
    else $error("sleep entered with never-sleep");
  a_sleep_wake: assert property (s_q.pwr == PWR_SLEEP && (powerBtn || wake) |=>
                                 s_q.pwr == PWR_ON)
    else $error("sleep did not wake");
  a_bus_answer: assert property (access && avs_waitrequest |=> !avs_waitrequest ##1
                                 avs_waitrequest)
    else $error("bus answer timing wrong");

  c_fallback: cover property (s_q.autoMode && shownValid ##1
                              shownValid && shownInput != $past(shownInput));
  c_standby: cover property (s_q.pwr == PWR_ON ##1 s_q.pwr == PWR_STANDBY);
  c_sleep: cover property (s_q.pwr == PWR_STANDBY ##1 s_q.pwr == PWR_SLEEP);
  c_wake: cover property (s_q.pwr == PWR_SLEEP ##1 s_q.pwr == PWR_ON);

endmodule

//--- sim/vispt_src_model.sv
// Purpose: Video sources and DDC/CI host facing the selector
// Assumes: Driven from the bench through the tasks below
// Notes:   Every change lands by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
module vispt_src_model
(
  input  wire logic  ref_clk,
  output logic [3:0] sigActive,
  output logic       powerBtn,
  output logic [3:0] mccsPwrReq,
  output logic       mccsPwrOn
);
  initial
  begin
    sigActive  = 4'h0;
    powerBtn   = 1'b0;
    mccsPwrReq = 4'h0;
    mccsPwrOn  = 1'b0;
  end

  task automatic set_sig(input logic [3:0] s);
    @(posedge ref_clk);
    sigActive <= s;
  endtask

  task automatic press();
    @(posedge ref_clk);
    powerBtn <= 1'b1;
    @(posedge ref_clk);
    powerBtn <= 1'b0;
  endtask

  // Qualifier rises and falls together with the one-cycle command pulse
  task automatic mccs_on(input logic [1:0] i);
    @(posedge ref_clk);
    mccsPwrReq <= 4'h1 << i;
    mccsPwrOn  <= 1'b1;
    @(posedge ref_clk);
    mccsPwrReq <= 4'h0;
    mccsPwrOn  <= 1'b0;
  endtask
endmodule

//--- sim/tb.sv
// Purpose: Self-checking bench for the input selector and power timers
// Assumes: TICK_CYCLES shortened to 10, so one second is 10 clocks
// Notes:   Rank model tracks slot to input; second instance is the two-input build
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
  import vispt_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, powerBtn, mccsPwrOn, shownValid, logoOn, valid2;
  logic [3:0]  sigActive, mccsPwrReq, ddcEnable;
  logic [1:0]  shownInput, powerState, shown2, lastPick, lastPick2;
  logic [31:0] rd2, rdB;
  logic        wait2, logo2;
  logic [3:0]  ddc2;
  logic [1:0]  pwr2;
  int          errCount, numChecks, cyc, seed;
  int          rankModel [4];

  always #10 ref_clk = ~ref_clk;

  vispt_src_model src (.ref_clk, .sigActive, .powerBtn, .mccsPwrReq, .mccsPwrOn);
  vispt_top #(.TICK_CYCLES(10)) dut
  (
    .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .sigActive, .powerBtn, .mccsPwrReq, .mccsPwrOn,
    .shownInput, .shownValid, .ddcEnable, .logoOn, .powerState
  );
  vispt_top #(.NUM_INPUTS(2), .TICK_CYCLES(10)) dut2
  (
    .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata(rd2), .avs_waitrequest(wait2), .sigActive, .powerBtn, .mccsPwrReq, .mccsPwrOn,
    .shownInput(shown2), .shownValid(valid2), .ddcEnable(ddc2), .logoOn(logo2), .powerState(pwr2)
  );

  task automatic stopTest();
    $display("Checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      errCount++;
      stopTest();
    end
  end

  // Holds the request until both builds are sampled with waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge ref_clk); while ((avs_waitrequest | wait2) !== 1'b0);
    q = avs_readdata;
    rdB = rd2;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Expected pick from the rank model; the last index stays when nothing is active
  task automatic pick_model(input logic [3:0] s, output logic f, output logic f2);
    f = 1'b0;
    f2 = 1'b0;
    for (int k = 3; k >= 0; k--)
    begin
      if (s[rankModel[k]]) begin lastPick = 2'(rankModel[k]); f = 1'b1; end
      if (s[rankModel[k]] && rankModel[k] < 2) begin lastPick2 = 2'(rankModel[k]); f2 = 1'b1; end
    end
  endtask

  task automatic move(input int i, input logic up);
    int s, t;
    logic f, f2;
    logic [7:0] e;
    s = 0;
    for (int k = 0; k < 4; k++) if (rankModel[k] == i) s = k;
    t = up ? s - 1 : s + 1;
    bus(1'b1, REG_MOVE, (up ? 32'h0000_0100 : 32'h0000_0200) | 32'(i), rd);
    if (t >= 0 && t < 4)
    begin
      rankModel[s] = rankModel[t];
      rankModel[t] = i;
    end
    // New ranking may change what is shown even with unchanged inputs
    pick_model(sigActive, f, f2);
    bus(1'b0, REG_PRIO, 32'h0000_0000, rd);
    e = {2'(rankModel[3]), 2'(rankModel[2]), 2'(rankModel[1]), 2'(rankModel[0])};
    `CHK({rd[7:0], rdB[7:0]}, {e, e})
  endtask

  task automatic check_auto(input logic [3:0] s);
    logic f, f2;
    src.set_sig(s);
    repeat (2) @(posedge ref_clk);
    #1;
    pick_model(s, f, f2);
    `CHK({shownValid, shownInput}, {f, lastPick})
    `CHK({valid2, shown2}, {f2, lastPick2})
  endtask

  task automatic wait_state(input logic [1:0] p, input int n);
    int k;
    k = 0;
    #1;
    while (powerState !== p && k < n) begin @(posedge ref_clk); #1; k++; end
    `CHK(powerState, p)
  endtask

  task automatic settle_chk(input int n, input logic [1:0] p);
    repeat (n) @(posedge ref_clk);
    #1;
    `CHK(powerState, p)
  endtask

  initial
  begin
    seed = 32'h5640;
    lastPick = 2'h0;
    lastPick2 = 2'h0;
    for (int k = 0; k < 4; k++) rankModel[k] = k;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK({logoOn, powerState, ddcEnable, logo2, pwr2, ddc2}, {1'b0, PWR_ON, 4'hF, 1'b0, PWR_ON, 4'h3})
    bus(1'b0, 8'h40, 32'h0000_0000, rd);
    `CHK({rd, rdB}, 64'h0000_0000_0000_0000)
    // Automatic scan with rank changes, boundaries included
    for (int n = 0; n < 24; n++)
    begin
      check_auto(4'($random(seed)));
      if (n == 4) move(3, 1'b1);
      if (n == 8) move(1, 1'b1);
      if (n == 10) move(1, 1'b1);
      if (n == 14) move(rankModel[3], 1'b0);
      if (n == 18) move(0, 1'b0);
    end
    // Manual input, then each command-channel mode
    bus(1'b1, REG_CTRL, 32'h0000_0000, rd);
    bus(1'b1, REG_SELECT, 32'h0000_0012, rd);
    for (int n = 0; n < 4; n++)
    begin
      src.set_sig(4'($random(seed)));
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK({shownValid, shownInput}, {sigActive[2], 2'h2})
      `CHK({valid2, shown2}, {sigActive[0], 2'h0})
      `CHK({ddcEnable, ddc2}, {4'h2, 4'h2})
    end
    // Enables follow the mode one edge after the write lands
    bus(1'b1, REG_CTRL, 32'h0000_0002, rd);
    @(posedge ref_clk);
    #1;
    `CHK({ddcEnable, ddc2}, {4'hF, 4'h3})
    bus(1'b1, REG_CTRL, 32'h0000_0004, rd);
    @(posedge ref_clk);
    #1;
    `CHK({ddcEnable, ddc2}, {4'h0, 4'h0})
    bus(1'b1, REG_CTRL, 32'h0000_0006, rd);
    @(posedge ref_clk);
    #1;
    `CHK({ddcEnable, ddc2}, {4'h0, 4'h0})
    // Power timers: standby 3 s, sleep 3 min
    bus(1'b1, REG_CTRL, 32'h0000_0003, rd);
    bus(1'b1, REG_TIMEOUT, 32'h0000_0000, rd);
    src.set_sig(4'h1);
    src.set_sig(4'h0);
    repeat (20) @(posedge ref_clk);
    src.set_sig(4'h1);
    repeat (20) @(posedge ref_clk);
    src.set_sig(4'h0);
    settle_chk(25, PWR_ON);
    wait_state(PWR_STANDBY, 12);
    src.set_sig(4'h4);
    settle_chk(2, PWR_ON);
    src.set_sig(4'h0);
    wait_state(PWR_STANDBY, 40);
    settle_chk(1700, PWR_STANDBY);
    wait_state(PWR_SLEEP, 150);
    src.set_sig(4'h1);
    settle_chk(3, PWR_SLEEP);
    src.press();
    settle_chk(2, PWR_ON);
    src.press();
    settle_chk(2, PWR_SLEEP);
    bus(1'b1, REG_CTRL, 32'h0000_0005, rd);
    src.mccs_on(2'h0);
    settle_chk(2, PWR_SLEEP);
    bus(1'b1, REG_CTRL, 32'h0000_0003, rd);
    src.mccs_on(2'h2);
    settle_chk(2, PWR_ON);
    bus(1'b1, REG_TIMEOUT, 32'h0000_0550, rd);
    // Lane masking, out-of-range sleep code refused, persistent logo code kept
    avs_byteenable <= 4'h2;
    bus(1'b1, REG_TIMEOUT, 32'h0000_0A0B, rd);
    avs_byteenable <= 4'h1;
    bus(1'b1, REG_TIMEOUT, 32'h0000_0359, rd);
    avs_byteenable <= 4'hF;
    bus(1'b0, REG_TIMEOUT, 32'h0000_0000, rd);
    `CHK({rd, rdB}, {32'h0000_0559, 32'h0000_0559})
    src.set_sig(4'h0);
    settle_chk(60, PWR_ON);
    stopTest();
  end
endmodule
